/* pkg/prs_pkg.sv */
// shared constants and types for the proximity result and status register bank
package prs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int RESULT_W = 16;
   localparam int BYTE_W   = 8;
   localparam int PTR_W    = 5;
   localparam int CNT_W    = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register pointers, as carried in the low bits of the command byte
   localparam logic [PTR_W-1:0] ADDR_PART_ID = 5'h12;
   localparam logic [PTR_W-1:0] ADDR_STATUS  = 5'h13;
   localparam logic [PTR_W-1:0] ADDR_RES_LO  = 5'h18;
   localparam logic [PTR_W-1:0] ADDR_RES_HI  = 5'h19;
   localparam logic [PTR_W-1:0] ADDR_OFFSET  = 5'h1e;

   ////////////////////////////////////////////////////////////////////////////
   // status byte layout
   localparam int STAT_SAT_BIT   = 6;
   localparam int STAT_IRQ_BIT   = 5;
   localparam int STAT_VALID_BIT = 1;

   // offset byte layout and reset value
   localparam int              OFFSET_SIGN_BIT = 7;
   localparam logic [BYTE_W-1:0] OFFSET_RESET  = 8'h00;
   localparam logic [BYTE_W-1:0] READ_ZERO     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // command byte layout and transfer types
   localparam int         CMD_TYPE_HI   = 6;
   localparam int         CMD_TYPE_LO   = 5;
   localparam logic [1:0] TYPE_REPEAT   = 2'h0;
   localparam logic [1:0] TYPE_AUTO_INC = 2'h1;

   // serial bit counting
   localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   localparam logic [CNT_W-1:0] CNT_ZERO      = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE       = 4'h1;

   ////////////////////////////////////////////////////////////////////////////
   // serial slave states
   typedef enum logic [2:0] {
      PRS_IDLE     = 3'b000,
      PRS_ADDR     = 3'b001,
      PRS_ADDR_ACK = 3'b010,
      PRS_WR_BYTE  = 3'b011,
      PRS_WR_ACK   = 3'b100,
      PRS_RD_BYTE  = 3'b101,
      PRS_RD_ACK   = 3'b110
   } prs_bus_state_t;

   // state of the register bank on the system clock
   typedef struct packed {
      logic                scl_s1;
      logic                scl_s2;
      logic                scl_d;
      logic                sda_s1;
      logic                sda_s2;
      logic                sda_d;
      logic                req_s1;
      logic                req_s2;
      logic                ack;
      prs_bus_state_t      bus;
      logic [CNT_W-1:0]    bitcnt;
      logic [BYTE_W-1:0]   shift;
      logic [BYTE_W-1:0]   tx;
      logic                rw;
      logic                first;
      logic                auto_inc;
      logic                host_ack;
      logic [PTR_W-1:0]    ptr;
      logic                sda_lvl;
      logic                sda_drive;
      logic [BYTE_W-1:0]   offset;
      logic [RESULT_W-1:0] result;
      logic [BYTE_W-1:0]   shadow;
      logic                sat;
      logic                valid;
      logic                irq;
   } prs_regs_state_t;

   // state of the capture logic on the link clock
   typedef struct packed {
      logic                rst_s1;
      logic                rst_s2;
      logic                ack_s1;
      logic                ack_s2;
      logic                req;
      logic [RESULT_W-1:0] data;
      logic                sat;
   } prs_link_state_t;

endpackage

/* pkg/prs_xfer_if.sv */
`timescale 1ns/100ps
`default_nettype none

// toggle handshake carrying one measurement from the link clock to the system clock
interface prs_xfer_if;
   logic        req;
   logic        ack;
   logic [15:0] data;
   logic        sat;

   modport link (
      output req,
      output data,
      output sat,
      input  ack
   );

   modport sys (
      input  req,
      input  data,
      input  sat,
      output ack
   );
endinterface

`default_nettype wire

/* logic/prs_link_capture.sv */
`timescale 1ns/100ps
`default_nettype none

// catches a finished measurement on the link clock when the previous word has been acked, and offers it across
module prs_link_capture
   import prs_pkg::*;
(
   // link clock and system reset
   input  wire logic                link_clk,
   input  wire logic                resetn,
   // measurement engine
   input  wire logic                cycle_done,
   input  wire logic [RESULT_W-1:0] raw_result,
   input  wire logic                raw_sat,
   // crossing to the register bank
   prs_xfer_if.link                 xfer
);
   import prs_pkg::*;

   prs_link_state_t s;
   prs_link_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_s        = s;
      // reset and returning ack pass two flops each
      next_s.rst_s1 = resetn;
      next_s.rst_s2 = s.rst_s1;
      next_s.ack_s1 = xfer.ack;
      next_s.ack_s2 = s.ack_s1;
      if (!s.rst_s2) begin
         next_s.req  = 1'b0;
         next_s.data = '0;
         next_s.sat  = 1'b0;
      end else if (cycle_done && (s.req == s.ack_s2)) begin
         // data held until the far side acks, then a new word may go
         next_s.data = raw_result;
         next_s.sat  = raw_sat;
         next_s.req  = ~s.req;
      end
   end

   // state register
   always_ff @(posedge link_clk) begin
      s <= next_s;
   end

   // outputs to the crossing
   assign xfer.req  = s.req;
   assign xfer.data = s.data;
   assign xfer.sat  = s.sat;

endmodule

`default_nettype wire

/* logic/prs_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module prs_regs
   import prs_pkg::*;
#(
   parameter logic [BYTE_W-1:0] PART_ID  = 8'ha5,  // arbitrary value
   parameter logic [6:0]        DEV_ADDR = 7'h39
)
(
   // system clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // serial bus pins, open drain
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe,
   // measurement engine, on the link clock
   input  wire logic                link_clk,
   input  wire logic                prox_cycle_done,
   input  wire logic [RESULT_W-1:0] prox_raw_result,
   input  wire logic                prox_raw_saturated,
   // device state, on the system clock
   input  wire logic                prox_irq_flag,
   input  wire logic                prox_enable_bit,
   // offset setting to the analog front end
   output logic [BYTE_W-1:0]        offset_value
);
   import prs_pkg::*;

   prs_regs_state_t s;
   prs_regs_state_t next_s;
   prs_xfer_if      xfer ();

   ////////////////////////////////////////////////////////////////////////////
   // measurement capture on the link clock
   prs_link_capture u_capture (
      .link_clk   (link_clk),
      .resetn     (resetn),
      .cycle_done (prox_cycle_done),
      .raw_result (prox_raw_result),
      .raw_sat    (prox_raw_saturated),
      .xfer       (xfer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read data for a register pointer
   function automatic logic [BYTE_W-1:0] reg_read(input prs_regs_state_t st,
                                                  input logic [PTR_W-1:0] a);
      logic [BYTE_W-1:0] status;
      status                 = READ_ZERO;
      status[STAT_SAT_BIT]   = st.sat;
      status[STAT_IRQ_BIT]   = st.irq;
      status[STAT_VALID_BIT] = st.valid;
      reg_read               = READ_ZERO;
      if (a == ADDR_PART_ID) begin
         reg_read = PART_ID;
      end else if (a == ADDR_STATUS) begin
         reg_read = status;
      end else if (a == ADDR_RES_LO) begin
         reg_read = st.result[BYTE_W-1:0];
      end else if (a == ADDR_RES_HI) begin
         reg_read = st.shadow;
      end else if (a == ADDR_OFFSET) begin
         reg_read = st.offset;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic              scl_rise;
      logic              scl_fall;
      logic              start_cond;
      logic              stop_cond;
      logic              arrive;
      logic              load;
      logic [BYTE_W-1:0] rd_byte;
      scl_rise   = 1'b0;
      scl_fall   = 1'b0;
      start_cond = 1'b0;
      stop_cond  = 1'b0;
      arrive     = 1'b0;
      load       = 1'b0;
      rd_byte    = READ_ZERO;
      next_s     = s;

      // pins and the request toggle pass two flops
      next_s.scl_s1 = scl_i;
      next_s.scl_s2 = s.scl_s1;
      next_s.scl_d  = s.scl_s2;
      next_s.sda_s1 = sda_i;
      next_s.sda_s2 = s.sda_s1;
      next_s.sda_d  = s.sda_s2;
      next_s.req_s1 = xfer.req;
      next_s.req_s2 = s.req_s1;

      // bus events from the synchronised pins
      scl_rise   = s.scl_s2 & ~s.scl_d;
      scl_fall   = ~s.scl_s2 & s.scl_d;
      start_cond = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
      stop_cond  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

      // new measurement: data stable while the toggle is unanswered
      arrive = s.req_s2 != s.ack;
      if (arrive) begin
         next_s.ack    = s.req_s2;
         next_s.result = xfer.data;
         next_s.sat    = xfer.sat;
      end

      // interrupt mirror and valid flag
      next_s.irq = prox_irq_flag;
      if (!prox_enable_bit) begin
         next_s.valid = 1'b0;
      end else if (arrive) begin
         next_s.valid = 1'b1;
      end

      // serial slave
      if (start_cond) begin
         next_s.bus       = PRS_ADDR;
         next_s.bitcnt    = CNT_ZERO;
         next_s.sda_drive = 1'b0;
      end else if (stop_cond) begin
         next_s.bus       = PRS_IDLE;
         next_s.sda_drive = 1'b0;
      end else if (scl_rise) begin
         // host data is sampled while the clock is high
         if ((s.bus == PRS_ADDR) || (s.bus == PRS_WR_BYTE)) begin
            next_s.shift  = {s.shift[BYTE_W-2:0], s.sda_s2};
            next_s.bitcnt = s.bitcnt + CNT_ONE;
         end else if (s.bus == PRS_RD_ACK) begin
            next_s.host_ack = ~s.sda_s2;
         end
      end else if (scl_fall) begin
         // our drive changes only while the clock is low
         unique case (s.bus)
            PRS_IDLE: begin
               next_s.sda_drive = 1'b0;
            end
            PRS_ADDR: begin
               if (s.bitcnt == BITS_PER_BYTE) begin
                  if (s.shift[BYTE_W-1:1] == DEV_ADDR) begin
                     next_s.sda_drive = 1'b1;
                     next_s.rw        = s.shift[0];
                     next_s.bus       = PRS_ADDR_ACK;
                  end else begin
                     next_s.bus = PRS_IDLE;
                  end
               end
            end
            PRS_ADDR_ACK: begin
               next_s.sda_drive = 1'b0;
               next_s.bitcnt    = CNT_ZERO;
               if (s.rw) begin
                  load = 1'b1;
               end else begin
                  next_s.bus   = PRS_WR_BYTE;
                  next_s.first = 1'b1;
               end
            end
            PRS_WR_BYTE: begin
               if (s.bitcnt == BITS_PER_BYTE) begin
                  next_s.sda_drive = 1'b1;
                  next_s.bus       = PRS_WR_ACK;
                  if (s.first) begin
                     // first byte after the address is the command byte
                     next_s.first    = 1'b0;
                     next_s.ptr      = s.shift[PTR_W-1:0];
                     next_s.auto_inc = s.shift[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_AUTO_INC;
                  end else begin
                     // only the offset takes writes
                     if (s.ptr == ADDR_OFFSET) begin
                        next_s.offset = s.shift;
                     end
                     next_s.ptr = s.ptr + {{(PTR_W-1){1'b0}}, s.auto_inc};
                  end
               end
            end
            PRS_WR_ACK: begin
               next_s.sda_drive = 1'b0;
               next_s.bitcnt    = CNT_ZERO;
               next_s.bus       = PRS_WR_BYTE;
            end
            PRS_RD_BYTE: begin
               if (s.bitcnt == BITS_PER_BYTE) begin
                  next_s.sda_drive = 1'b0;
                  next_s.bus       = PRS_RD_ACK;
               end else begin
                  next_s.tx        = {s.tx[BYTE_W-2:0], 1'b0};
                  next_s.sda_drive = ~s.tx[BYTE_W-2];
                  next_s.bitcnt    = s.bitcnt + CNT_ONE;
               end
            end
            PRS_RD_ACK: begin
               if (s.host_ack) begin
                  load = 1'b1;
               end else begin
                  next_s.bus = PRS_IDLE;
               end
            end
            default: begin
               next_s.bus       = PRS_IDLE;
               next_s.sda_drive = 1'b0;
            end
         endcase
      end

      // fetch the next read byte and drive its first bit
      if (load) begin
         rd_byte          = reg_read(s, s.ptr);
         next_s.tx        = rd_byte;
         next_s.sda_drive = ~rd_byte[BYTE_W-1];
         next_s.bitcnt    = CNT_ONE;
         next_s.bus       = PRS_RD_BYTE;
         next_s.ptr       = s.ptr + {{(PTR_W-1){1'b0}}, s.auto_inc};
         if (s.ptr == ADDR_RES_LO) begin
            // high byte frozen from the same word as the low byte
            next_s.shadow = s.result[RESULT_W-1:BYTE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s        <= '0;
         s.offset <= OFFSET_RESET;
         // pin syncs start at the idle high level, no false edge after reset
         s.scl_s1 <= 1'b1;
         s.scl_s2 <= 1'b1;
         s.scl_d  <= 1'b1;
         s.sda_s1 <= 1'b1;
         s.sda_s2 <= 1'b1;
         s.sda_d  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign xfer.ack     = s.ack;
   assign sda_o        = s.sda_lvl;
   assign sda_oe       = s.sda_drive;
   assign offset_value = s.offset;

endmodule

`default_nettype wire

/* verification/prs_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// port level watch of the register bank
module prs_regs_chk
   import prs_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // serial pins
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   input  wire logic              sda_o,
   input  wire logic              sda_oe,
   // offset setting
   input  wire logic [BYTE_W-1:0] offset_value
);
   default clocking cb @(posedge clk); endclocking

   ////////////////////////////////////////////////////////////////////////////
   // reset state, and the data pin output held low outside reset
   property p_rst_off; !resetn |=> offset_value == OFFSET_RESET; endproperty
   a_rst_off: assert property (p_rst_off) else $error("offset not cleared");
   property p_rst_oe; !resetn |=> !sda_oe; endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("data pin held in reset");
   property p_sda_o; disable iff (!resetn) sda_o == 1'b0; endproperty
   a_sda_o: assert property (p_sda_o) else $error("data pin driven high");

   ////////////////////////////////////////////////////////////////////////////
   // data pin moves only while the serial clock is low
   property p_oe_rise; disable iff (!resetn) $rose(sda_oe) |-> !scl_i && !$past(scl_i, 2); endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("drive began with clock high");
   property p_oe_fall; disable iff (!resetn) $fell(sda_oe) |-> !scl_i; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("drive ended with clock high");
   property p_oe_hold; disable iff (!resetn) scl_i [*5] |-> $stable(sda_oe); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("data changed in clock high");

   // a quiet bus changes nothing
   property p_off_idle; disable iff (!resetn) $stable(scl_i) [*8] |-> $stable(offset_value); endproperty
   a_off_idle: assert property (p_off_idle) else $error("offset moved on idle bus");
   property p_oe_idle; disable iff (!resetn) ($stable(scl_i) && $stable(sda_i)) [*8] |-> $stable(sda_oe); endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("data moved on idle bus");

   // main scenarios reached
   c_ack: cover property (disable iff (!resetn) $rose(sda_oe));
   c_off: cover property (disable iff (!resetn) !$stable(offset_value));
   c_hi: cover property (disable iff (!resetn) sda_oe && scl_i);
endmodule

bind prs_regs prs_regs_chk i_chk (
   .clk(clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .offset_value(offset_value)
);

`default_nettype wire

/* verification/prs_host.sv */
`timescale 1ns/100ps
`default_nettype none

// serial bus controller, open drain, quarter bit of 5 clocks
module prs_host (
   // bench clock
   input  wire logic clk,
   // data line level
   input  wire logic sda,
   // open drain drives
   output logic      scl,
   output logic      pull
);
   logic ak;

   initial begin
      scl = 1'b1;
      pull = 1'b0;
      ak = 1'b0;
   end

   // waits change on the falling clock edge
   task automatic q();
      repeat (5) @(negedge clk);
   endtask

   // one bit, data set only while clock low
   task automatic bit_io(input logic b, output logic r);
      q();
      pull = ~b;
      q();
      scl = 1'b1;
      q();
      q();
      r = sda;
      scl = 1'b0;
   endtask

   // start or repeated start
   task automatic start();
      q();
      pull = 1'b0;
      q();
      scl = 1'b1;
      q();
      pull = 1'b1;
      q();
      scl = 1'b0;
   endtask

   // stop, bus left released
   task automatic stop();
      q();
      pull = 1'b1;
      q();
      scl = 1'b1;
      q();
      pull = 1'b0;
      q();
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ok = ~r;
   endtask

   // host ack keeps the read going, nack ends it
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~more, r);
   endtask

   // command then n bytes, low byte first
   task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input logic rd, input int n,
                       input logic [15:0] w, output logic [15:0] v);
      logic ok;
      logic [7:0] b;
      v = 16'h0000;
      start();
      wbyte({a, 1'b0}, ak);
      wbyte(cmd, ok);
      if (rd) begin
         start();
         wbyte({a, 1'b1}, ok);
         for (int i = 0; i < n; i++) begin
            rbyte(i < n - 1, b);
            v[8*i+:8] = b;
         end
      end
      else begin
         for (int i = 0; i < n; i++) wbyte(w[8*i+:8], ok);
      end
      stop();
   endtask
endmodule

`default_nettype wire

/* verification/proximity_result_status_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module proximity_result_status_regs_tb;
   import prs_pkg::*;
   localparam logic [7:0] ID_V = 8'h5c; // arbitrary value
   localparam logic [6:0] DA   = 7'h39;
   logic        clk = 1'b0, lclk = 1'b0, resetn = 1'b0;
   logic        done = 1'b0, sat = 1'b0, irq = 1'b0, en = 1'b0;
   logic [15:0] raw = 16'h0000;
   logic        scl, pull, sda_oe, sda_o;
   logic [7:0]  off;
   wire logic   sda = ~(pull | sda_oe);
   int          error_cnt = 0, n_compared = 0;
   logic [31:0] seed = 32'h0802;
   // behavioural model state
   logic [15:0] m_res = 16'h0000;
   logic [7:0]  m_sh = 8'h00, m_off = 8'h00;
   logic        m_sat = 1'b0, m_val = 1'b0;

   always #2 clk = ~clk;
   initial #7 forever #24 lclk = ~lclk;

   prs_regs #(.PART_ID(ID_V), .DEV_ADDR(DA)) i_dut (
      .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .link_clk(lclk), .prox_cycle_done(done), .prox_raw_result(raw), .prox_raw_saturated(sat),
      .prox_irq_flag(irq), .prox_enable_bit(en), .offset_value(off));
   prs_host i_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected byte, low result read latches the shadow
   function automatic logic [7:0] mdl(input logic [4:0] p);
      case (p)
         5'h12: return ID_V;
         5'h13: return {1'b0, m_sat, irq, 3'b000, m_val, 1'b0};
         5'h18: begin
            m_sh = m_res[15:8];
            return m_res[7:0];
         end
         5'h19: return m_sh;
         5'h1e: return m_off;
         default: return 8'h00;
      endcase
   endfunction

   task automatic rd(input logic [4:0] p, input int n);
      logic [15:0] v, e;
      e = 16'h0000;
      for (int i = 0; i < n; i++) e[8*i+:8] = mdl(p + 5'(i));
      i_host.xfer(DA, {3'b001, p}, 1'b1, n, 16'h0000, v);
      `CHK("read", e, v)
   endtask

   task automatic wr(input logic [4:0] p, input logic [7:0] d);
      logic [15:0] v;
      if (p == 5'h1e) m_off = d;
      i_host.xfer(DA, {3'b001, p}, 1'b0, 1, {8'h00, d}, v);
      `CHK("addr ack", 1'b1, i_host.ak)
   endtask

   // one measurement across the link clock
   task automatic meas(input logic [15:0] r, input logic s);
      @(negedge lclk);
      done = 1'b1;
      raw = r;
      sat = s;
      @(negedge lclk);
      done = 1'b0;
      raw = ~r;
      sat = ~s;
      repeat (8) @(negedge lclk);
      m_res = r;
      m_sat = s;
      if (en) m_val = 1'b1;
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog
   initial begin
      #200us;
      error_cnt++;
      test_done();
   end

   initial begin
      logic [15:0] v;
      repeat (16) @(negedge clk);
      repeat (4) @(posedge lclk);
      @(negedge clk);
      resetn = 1'b1;
      rd(5'h12, 1);
      rd(5'h13, 1);
      rd(5'h1e, 1);
      `CHK("offset pin", 8'h00, off)
      rd(5'h19, 1);
      $display("test reset done");
      wr(5'h12, 8'(rnd()));
      wr(5'h13, 8'(rnd()));
      wr(5'h18, 8'(rnd()));
      rd(5'h12, 2);
      rd(5'h00, 1);
      // repeated byte type: the pointer stays on the id byte
      i_host.xfer(DA, {3'b000, 5'h12}, 1'b1, 2, 16'h0000, v);
      `CHK("no increment", {ID_V, ID_V}, v)
      $display("test read only done");
      for (int k = 0; k < 6; k++) begin
         wr(5'h1e, k == 0 ? 8'h80 : (k == 1 ? 8'h7f : 8'(rnd())));
         rd(5'h1e, 1);
         `CHK("offset pin", m_off, off)
      end
      $display("test offset done");
      // mid-run reset brings the offset and shadow back to zero
      @(negedge clk);
      resetn = 1'b0;
      repeat (4) @(posedge lclk);
      @(negedge clk);
      resetn = 1'b1;
      m_off = 8'h00;
      m_sh = 8'h00;
      m_res = 16'h0000;
      `CHK("offset pin", 8'h00, off)
      rd(5'h1e, 1);
      rd(5'h19, 1);
      $display("test mid reset done");
      @(negedge clk);
      en = 1'b1;
      irq = 1'b1;
      meas(16'(rnd()), 1'b1);
      rd(5'h13, 1);
      @(negedge clk);
      en = 1'b0;
      irq = 1'b0;
      m_val = 1'b0;
      repeat (4) @(negedge clk);
      rd(5'h13, 1);
      meas(16'(rnd()), 1'b0);
      rd(5'h13, 1);
      $display("test status done");
      for (int k = 0; k < 4; k++) begin
         meas(16'(rnd()), 1'b0);
         rd(5'h18, 2);
      end
      meas(16'(rnd()), 1'b0);
      rd(5'h18, 1);
      meas(16'(rnd()), 1'b0);
      rd(5'h19, 1);
      rd(5'h19, 1);
      $display("test shadow done");
      i_host.xfer(7'h22, {3'b001, 5'h12}, 1'b1, 1, 16'h0000, v);
      `CHK("foreign ack", 1'b0, i_host.ak)
      `CHK("foreign read", 16'h00ff, v)
      rd(5'h12, 1);
      $display("test address done");
      test_done();
   end
endmodule

`default_nettype wire
